/* rtl/tts_mem.sv */
// Trace buffer memory: one write port, registered read data.
// Assumes write and read on the same clock; read data lag the address by one edge.
`timescale 1ns/1ps
module tts_mem #(
  parameter int W = 44,
  parameter int D = 64,
  parameter int AW = 6
) (
  input wire logic clk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [W-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [W-1:0] rdata
);
  logic [W-1:0] mem_ff [D];

  always_ff @(posedge clk)
  begin
    if (we)
      mem_ff[waddr] <= wdata;
    rdata <= mem_ff[raddr];
  end
endmodule : tts_mem

/* rtl/tts_pkg.sv */
// Constants, field layout and types of the two-level trace trigger sequencer.
// Assumes a 32-bit AXI4-Lite register bus with an 8-bit byte address.
package tts_pkg;
  localparam int AW = 24;
  localparam int DW = 16;
  localparam int SW = 4;
  localparam int EW = AW + DW + SW;
  localparam int NRES = 4;
  localparam int DEPTH = 64;
  localparam int PW = 6;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STAT = 8'h04;
  localparam logic [7:0] OFF_QUAL0 = 8'h08;
  localparam logic [7:0] OFF_QUAL1 = 8'h0c;
  localparam logic [7:0] OFF_COUNT = 8'h10;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h14;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h18;
  localparam logic [7:0] OFF_BUF_IDX = 8'h1c;
  localparam logic [7:0] OFF_BUF_ADDR = 8'h20;
  localparam logic [7:0] OFF_BUF_DS = 8'h24;
  localparam logic [1:0] RES_REGION = 2'h1;
  localparam logic [1:0] RF_LO = 2'h0;
  localparam logic [1:0] RF_HI = 2'h1;
  localparam logic [1:0] RF_DATA = 2'h2;
  localparam logic [1:0] RF_STAT = 2'h3;
  localparam int CTRL_ARM = 0;
  localparam int CTRL_POS = 1;
  localparam int CTRL_BRK = 3;
  localparam int CTRL_CNT = 4;
  localparam int CTRL_STOP = 6;
  localparam logic [1:0] POS_START = 2'h0;
  localparam logic [1:0] POS_CENTRE = 2'h1;
  localparam logic [1:0] POS_END = 2'h2;
  localparam logic [1:0] CNT_TIME = 2'h1;
  localparam logic [1:0] CNT_STATE = 2'h2;
  localparam int Q_ANY = 4;
  localparam int Q_NOT = 5;
  localparam int Q_ESTORE = 0;
  localparam int Q_ENABLE = 1;
  localparam int Q_TSTORE = 2;
  localparam int Q_TRIGGER = 3;
  localparam int Q_STORE = 4;
  localparam int Q_RESTART = 5;
  localparam int Q_PRESTORE = 6;
  localparam int Q_COUNT = 7;
  localparam int IRQ_TRIG = 0;
  localparam int IRQ_DONE = 1;
  localparam logic [31:0] CTRL_RST = 32'h00000010;
  localparam logic [31:0] QUAL0_RST = 32'h10101010;
  localparam logic [31:0] QUAL1_RST = 32'h10000010;
  localparam logic [31:0] RES_HI_RST = 32'h00ffffff;
  localparam logic [PW:0] LIM_START = 7'h40;
  localparam logic [PW:0] LIM_CENTRE = 7'h20;
  localparam logic [PW:0] LIM_END = 7'h01;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  typedef enum logic [2:0] {SQ_IDLE, SQ_LVL1, SQ_LVL2, SQ_POST, SQ_DONE} tts_seq_t;
endpackage : tts_pkg

/* rtl/tts_seq.sv */
// Two-level trace trigger sequencer with AXI4-Lite registers and trace buffer.
// Assumes captured states arrive as a valid level from the target bus domain,
// rising at least four MCLK cycles apart, with the fields stable meanwhile.
// Summary of operation
// - After arming the sequencer sits at level one, storing enable-store states and watching for enable.
// - An enable state moves it to level two, storing trigger-store states and watching for the trigger.
// - A trigger state starts the post-trigger phase, where store-qualified states and the prestore states ahead of them are kept.
// - A restart state before the trigger sends the sequencer back to level one.
// - Qualifiers are built by combining address range, data and status resources.
// - A counter counts time, counts states of a chosen qualifier, or is off.
// - Up to two recent prestore states are written ahead of each normally stored state.
// - Trigger at start puts the trigger state first, followed only by post-trigger states.
// - Trigger at centre puts the trigger state in the middle with half the buffer on each side.
// - Trigger at end makes the trigger state the last entry and stops capture there.
// - Break on trigger raises a request into the monitor when the trigger occurs.
// - A state holds a sixteen-bit data field with per-bit don't-care and a bus cycle status.
`timescale 1ns/1ps
module tts_seq
  import tts_pkg::*;
(
  input wire logic MCLK,
  input wire logic SYS_RST,
  input wire logic CAP_VALID,
  input wire logic [AW-1:0] CAP_ADDR,
  input wire logic [DW-1:0] CAP_DATA,
  input wire logic [SW-1:0] CAP_STAT,
  input wire logic [7:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire logic [7:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  output logic BREAK_REQ,
  output logic IRQ
);
  function automatic logic qual(input logic [7:0] q, input logic [NRES-1:0] h);
    qual = (q[Q_ANY] | (|(q[NRES-1:0] & h))) ^ q[Q_NOT];
  endfunction : qual

  function automatic logic is_res(input logic [7:0] a);
    is_res = a[7:6] == RES_REGION;
  endfunction : is_res

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s);
    for (int b = 0; b < 4; b++)
      o[8*b+:8] = s[b] ? n[8*b+:8] : o[8*b+:8];
    merge = o;
  endfunction : merge

  logic [EW:0] s1_ff, s2_ff;
  logic v3_ff;
  logic [7:0] awa_ff;
  logic [31:0] wd_ff;
  logic [3:0] ws_ff;
  logic [31:0] ctrl_ff, qual0_ff, qual1_ff, cnt_ff, mask_ff, bidx_ff;
  logic [31:0] rlo_ff [NRES];
  logic [31:0] rhi_ff [NRES];
  logic [31:0] rdat_ff [NRES];
  logic [31:0] rst_ff [NRES];
  logic [1:0] irq_st_ff;
  tts_seq_t seq_ff;
  logic [EW-1:0] q_ff [3];
  logic [EW-1:0] pre_ff [2];
  logic [1:0] q_cnt_ff, pre_n_ff;
  logic [PW-1:0] wr_ptr_ff, trig_ptr_ff;
  logic [PW:0] post_cnt_ff, post_lim;
  logic trig_ff;
  logic [EW-1:0] cur, mem_rd;
  logic [NRES-1:0] hit;
  logic [7:0] qh;
  logic st_ev, trig_ev, store_ev, run, arm, stop, do_wr, rd_go, lim_hit, wr_en, done_ev;
  logic [31:0] rd_d;
  logic rd_ok;
  logic [1:0] pos;

  // Whole state crosses as one word; the level edge is taken after the second stage
  always_ff @(posedge MCLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      s1_ff <= '0;
      s2_ff <= '0;
      v3_ff <= 1'b0;
    end
    else
    begin
      s1_ff <= {CAP_VALID, CAP_STAT, CAP_DATA, CAP_ADDR};
      s2_ff <= s1_ff;
      v3_ff <= s2_ff[EW];
    end
  end

  assign cur = s2_ff[EW-1:0];
  assign st_ev = s2_ff[EW] && !v3_ff;
  assign pos = ctrl_ff[CTRL_POS+:2];
  assign run = seq_ff == SQ_LVL1 || seq_ff == SQ_LVL2 || seq_ff == SQ_POST;

  // Mask bit set means compare; a cleared data byte mask matches byte cycles
  genvar g;
  generate
    for (g = 0; g < NRES; g++)
    begin : g_res
      assign hit[g] = cur[AW-1:0] >= rlo_ff[g][AW-1:0] && cur[AW-1:0] <= rhi_ff[g][AW-1:0]
        && ((cur[AW+DW-1:AW] ^ rdat_ff[g][15:0]) & rdat_ff[g][31:16]) == '0
        && ((cur[EW-1:AW+DW] ^ rst_ff[g][3:0]) & rst_ff[g][7:4]) == '0;
    end
    for (g = 0; g < 8; g++)
    begin : g_qual
      assign qh[g] = qual(g < 4 ? qual0_ff[8*(g%4)+:8] : qual1_ff[8*(g%4)+:8], hit);
    end
  endgenerate

  assign trig_ev = st_ev && seq_ff == SQ_LVL2 && qh[Q_TRIGGER] && !qh[Q_RESTART];
  assign post_lim = pos == POS_START ? LIM_START : (pos == POS_CENTRE ? LIM_CENTRE : LIM_END);
  assign lim_hit = post_cnt_ff >= post_lim;
  assign wr_en = q_cnt_ff != 2'h0 && (!trig_ff || !lim_hit);
  assign done_ev = seq_ff == SQ_POST && lim_hit;

  always_comb
  begin
    store_ev = 1'b0;
    if (st_ev && !trig_ev)
      case (seq_ff)
        SQ_LVL1: store_ev = qh[Q_ESTORE] && pos != POS_START;
        SQ_LVL2: store_ev = qh[Q_TSTORE] && pos != POS_START;
        SQ_POST: store_ev = qh[Q_STORE] && pos != POS_END && !lim_hit;
        default: store_ev = 1'b0;
      endcase
  end

  always_ff @(posedge MCLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      seq_ff <= SQ_IDLE;
    else if (stop)
      seq_ff <= SQ_IDLE;
    else if (arm)
      seq_ff <= SQ_LVL1;
    else
      case (seq_ff)
        SQ_LVL1: if (st_ev && qh[Q_ENABLE] && !qh[Q_RESTART]) seq_ff <= SQ_LVL2;
        SQ_LVL2: if (st_ev && qh[Q_RESTART]) seq_ff <= SQ_LVL1;
          else if (trig_ev) seq_ff <= SQ_POST;
        SQ_POST: if (done_ev) seq_ff <= SQ_DONE;
        default: seq_ff <= seq_ff;
      endcase
  end

  // Prestored states are queued oldest first, ahead of the state that pulls them in
  always_ff @(posedge MCLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      q_ff <= '{default: '0};
      q_cnt_ff <= 2'h0;
    end
    else if (arm)
      q_cnt_ff <= 2'h0;
    else if (trig_ev)
    begin
      q_ff[0] <= cur;
      q_cnt_ff <= 2'h1;
    end
    else if (store_ev)
    begin
      q_ff[0] <= pre_n_ff == 2'h2 ? pre_ff[1] : (pre_n_ff == 2'h1 ? pre_ff[0] : cur);
      q_ff[1] <= pre_n_ff == 2'h2 ? pre_ff[0] : cur;
      q_ff[2] <= cur;
      q_cnt_ff <= pre_n_ff + 2'h1;
    end
    else if (q_cnt_ff != 2'h0)
    begin
      q_ff[0] <= q_ff[1];
      q_ff[1] <= q_ff[2];
      q_cnt_ff <= q_cnt_ff - 2'h1;
    end
  end

  always_ff @(posedge MCLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      pre_ff <= '{default: '0};
      pre_n_ff <= 2'h0;
    end
    else if (arm || trig_ev || store_ev)
      pre_n_ff <= 2'h0;
    else if (st_ev && run && qh[Q_PRESTORE])
    begin
      pre_ff[1] <= pre_ff[0];
      pre_ff[0] <= cur;
      pre_n_ff <= pre_n_ff == 2'h2 ? 2'h2 : pre_n_ff + 2'h1;
    end
  end

  always_ff @(posedge MCLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      wr_ptr_ff <= '0;
      trig_ptr_ff <= '0;
      post_cnt_ff <= '0;
      trig_ff <= 1'b0;
    end
    else if (arm)
    begin
      wr_ptr_ff <= '0;
      post_cnt_ff <= '0;
      trig_ff <= 1'b0;
    end
    else
    begin
      if (trig_ev && pos == POS_START)
        wr_ptr_ff <= '0;
      else if (wr_en)
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      if (trig_ev)
      begin
        trig_ff <= 1'b1;
        trig_ptr_ff <= pos == POS_START ? '0 : wr_ptr_ff;
      end
      if (trig_ff && wr_en)
        post_cnt_ff <= post_cnt_ff + 1'b1;
    end
  end

  always_ff @(posedge MCLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      cnt_ff <= '0;
    else if (arm)
      cnt_ff <= '0;
    else if (run && (ctrl_ff[CTRL_CNT+:2] == CNT_TIME ||
             (ctrl_ff[CTRL_CNT+:2] == CNT_STATE && st_ev && qh[Q_COUNT])))
      cnt_ff <= cnt_ff + 32'h1;
  end

  always_ff @(posedge MCLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      BREAK_REQ <= 1'b0;
      irq_st_ff <= 2'h0;
      IRQ <= 1'b0;
    end
    else
    begin
      BREAK_REQ <= trig_ev && ctrl_ff[CTRL_BRK];
      // A new event in the clearing read's cycle survives
      irq_st_ff <= (irq_st_ff & ~{2{rd_go && ARADDR == OFF_IRQ_STAT}}) | {done_ev, trig_ev};
      IRQ <= |(irq_st_ff & mask_ff[1:0]);
    end
  end

  tts_mem #(.W(EW), .D(DEPTH), .AW(PW)) u_mem (
    .clk(MCLK),
    .we(wr_en),
    .waddr(wr_ptr_ff),
    .wdata(q_ff[0]),
    .raddr(bidx_ff[PW-1:0]),
    .rdata(mem_rd)
  );

  // Address and data are held by dropping the ready; both re-open after the response
  assign do_wr = !AWREADY && !WREADY && !BVALID;
  assign arm = do_wr && awa_ff == OFF_CTRL && ws_ff[0] && wd_ff[CTRL_ARM];
  assign stop = do_wr && awa_ff == OFF_CTRL && ws_ff[0] && wd_ff[CTRL_STOP];
  assign rd_go = ARVALID && ARREADY;

  always_ff @(posedge MCLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      AWREADY <= 1'b1;
      WREADY <= 1'b1;
      BVALID <= 1'b0;
      BRESP <= RESP_OK;
      awa_ff <= '0;
      wd_ff <= '0;
      ws_ff <= '0;
    end
    else
    begin
      if (AWVALID && AWREADY)
      begin
        AWREADY <= 1'b0;
        awa_ff <= AWADDR;
      end
      if (WVALID && WREADY)
      begin
        WREADY <= 1'b0;
        wd_ff <= WDATA;
        ws_ff <= WSTRB;
      end
      if (do_wr)
      begin
        BVALID <= 1'b1;
        BRESP <= (is_res(awa_ff) || awa_ff == OFF_CTRL || awa_ff == OFF_QUAL0 || awa_ff == OFF_QUAL1 ||
                  awa_ff == OFF_IRQ_MASK || awa_ff == OFF_BUF_IDX) ? RESP_OK : RESP_ERR;
      end
      else if (BVALID && BREADY)
      begin
        BVALID <= 1'b0;
        AWREADY <= 1'b1;
        WREADY <= 1'b1;
      end
    end
  end

  always_ff @(posedge MCLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      ctrl_ff <= CTRL_RST;
      qual0_ff <= QUAL0_RST;
      qual1_ff <= QUAL1_RST;
      mask_ff <= '0;
      bidx_ff <= '0;
      rlo_ff <= '{default: '0};
      rhi_ff <= '{default: RES_HI_RST};
      rdat_ff <= '{default: '0};
      rst_ff <= '{default: '0};
    end
    else if (do_wr)
    begin
      case (awa_ff)
        OFF_CTRL: ctrl_ff <= merge(ctrl_ff, wd_ff, ws_ff);
        OFF_QUAL0: qual0_ff <= merge(qual0_ff, wd_ff, ws_ff);
        OFF_QUAL1: qual1_ff <= merge(qual1_ff, wd_ff, ws_ff);
        OFF_IRQ_MASK: mask_ff <= merge(mask_ff, wd_ff, ws_ff);
        OFF_BUF_IDX: bidx_ff <= merge(bidx_ff, wd_ff, ws_ff);
        default: ;
      endcase
      for (int i = 0; i < NRES; i++)
        if (is_res(awa_ff) && awa_ff[5:4] == 2'(i))
          case (awa_ff[3:2])
            RF_LO: rlo_ff[i] <= merge(rlo_ff[i], wd_ff, ws_ff);
            RF_HI: rhi_ff[i] <= merge(rhi_ff[i], wd_ff, ws_ff);
            RF_DATA: rdat_ff[i] <= merge(rdat_ff[i], wd_ff, ws_ff);
            default: rst_ff[i] <= merge(rst_ff[i], wd_ff, ws_ff);
          endcase
    end
  end

  always_comb
  begin
    rd_d = '0;
    rd_ok = 1'b1;
    if (is_res(ARADDR))
      case (ARADDR[3:2])
        RF_LO: rd_d = rlo_ff[ARADDR[5:4]];
        RF_HI: rd_d = rhi_ff[ARADDR[5:4]];
        RF_DATA: rd_d = rdat_ff[ARADDR[5:4]];
        default: rd_d = rst_ff[ARADDR[5:4]];
      endcase
    else
      case (ARADDR)
        OFF_CTRL: rd_d = ctrl_ff;
        OFF_STAT: rd_d = {10'h0, trig_ptr_ff, 2'h0, wr_ptr_ff, 3'h0, trig_ff, 1'b0, seq_ff};
        OFF_QUAL0: rd_d = qual0_ff;
        OFF_QUAL1: rd_d = qual1_ff;
        OFF_COUNT: rd_d = cnt_ff;
        OFF_IRQ_STAT: rd_d = {30'h0, irq_st_ff};
        OFF_IRQ_MASK: rd_d = mask_ff;
        OFF_BUF_IDX: rd_d = bidx_ff;
        OFF_BUF_ADDR: rd_d = {8'h0, mem_rd[AW-1:0]};
        OFF_BUF_DS: rd_d = {12'h0, mem_rd[EW-1:AW]};
        default: rd_ok = 1'b0;
      endcase
  end

  always_ff @(posedge MCLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      ARREADY <= 1'b1;
      RVALID <= 1'b0;
      RDATA <= '0;
      RRESP <= RESP_OK;
    end
    else if (rd_go)
    begin
      ARREADY <= 1'b0;
      RVALID <= 1'b1;
      RDATA <= rd_d;
      RRESP <= rd_ok ? RESP_OK : RESP_ERR;
    end
    else if (RVALID && RREADY)
    begin
      RVALID <= 1'b0;
      ARREADY <= 1'b1;
    end
  end

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SYS_RST);

  sequence s_trig;
    st_ev && seq_ff == SQ_LVL2 && qh[Q_TRIGGER] && !qh[Q_RESTART];
  endsequence
  sequence s_restart;
    st_ev && (seq_ff == SQ_LVL1 || seq_ff == SQ_LVL2) && qh[Q_RESTART];
  endsequence

  arm_level_one_a: assert property (arm && !stop |=> seq_ff == SQ_LVL1)
    else $error("arm did not enter level one");
  enable_advance_a: assert property (st_ev && seq_ff == SQ_LVL1 && qh[Q_ENABLE] && !qh[Q_RESTART]
    && !arm && !stop |=> seq_ff == SQ_LVL2)
    else $error("enable state did not advance");
  trigger_post_a: assert property (s_trig ##0 !arm && !stop |=> seq_ff == SQ_POST && trig_ff)
    else $error("trigger did not start post phase");
  restart_wins_a: assert property (s_restart ##0 !arm && !stop |=> seq_ff == SQ_LVL1)
    else $error("restart did not return to level one");
  count_time_a: assert property (run && !arm && ctrl_ff[CTRL_CNT+:2] == CNT_TIME
    |=> cnt_ff == $past(cnt_ff) + 32'h1)
    else $error("time count did not advance");
  prestore_order_a: assert property (store_ev && pre_n_ff == 2'h2 && !arm
    |=> q_cnt_ff == 2'h3 ##1 q_cnt_ff == 2'h2)
    else $error("prestore queue wrong");
  start_first_a: assert property (s_trig ##0 pos == POS_START && !arm |=> wr_en && wr_ptr_ff == '0)
    else $error("trigger state not first entry");
  end_stops_a: assert property (s_trig ##0 pos == POS_END && !arm && !stop ##1 !arm && !stop [*2]
    |=> seq_ff == SQ_DONE)
    else $error("capture did not stop at trigger");
  centre_limit_a: assert property (trig_ff && pos == POS_CENTRE |-> post_cnt_ff <= LIM_CENTRE)
    else $error("post-trigger half overrun");
  break_req_a: assert property (s_trig ##0 ctrl_ff[CTRL_BRK] |=> BREAK_REQ ##1 !BREAK_REQ)
    else $error("break request missing");
endmodule : tts_seq

/* testbench/tts_seq_tb.sv */
// Self-checking bench for the trace trigger sequencer.
// Assumes the target model spaces states well beyond the four-cycle minimum.
`timescale 1ns/1ps
module tts_seq_tb
  import tts_pkg::*;
;
  logic MCLK = 1'b0;
  logic SYS_RST = 1'b1;
  logic CAP_VALID;
  logic [AW-1:0] CAP_ADDR;
  logic [DW-1:0] CAP_DATA;
  logic [SW-1:0] CAP_STAT;
  logic [7:0] AWADDR = 8'h00;
  logic AWVALID = 1'b0;
  logic AWREADY;
  logic [31:0] WDATA = 32'h0;
  logic [3:0] WSTRB = 4'hf;
  logic WVALID = 1'b0;
  logic WREADY;
  logic [1:0] BRESP;
  logic BVALID;
  logic BREADY = 1'b0;
  logic [7:0] ARADDR = 8'h00;
  logic ARVALID = 1'b0;
  logic ARREADY;
  logic [31:0] RDATA;
  logic [1:0] RRESP;
  logic RVALID;
  logic RREADY = 1'b0;
  logic BREAK_REQ;
  logic IRQ;
  int n_checks = 0;
  int num_errors = 0;
  int cyc = 0;
  int brk_n = 0;
  int b0;
  logic [31:0] v;
  logic [31:0] st;
  logic [1:0] r;
  logic [5:0] idx;

  typedef struct packed {logic w; logic [7:0] a; logic [31:0] d; logic [1:0] r;} tts_rrow_t;
  typedef struct packed {logic [1:0] pos; logic brk; logic [2:0] seq;} tts_prow_t;
  tts_rrow_t rrows[17] = '{
    '{1'b0, OFF_CTRL, CTRL_RST, RESP_OK}, '{1'b0, OFF_QUAL0, QUAL0_RST, RESP_OK},
    '{1'b0, OFF_QUAL1, QUAL1_RST, RESP_OK}, '{1'b0, 8'h44, RES_HI_RST, RESP_OK},
    '{1'b0, 8'hfc, 32'h0, RESP_ERR}, '{1'b1, OFF_STAT, 32'h0, RESP_ERR}, '{1'b1, 8'hfc, 32'h1, RESP_ERR},
    '{1'b1, 8'h40, 32'h100, RESP_OK}, '{1'b1, 8'h44, 32'h1ff, RESP_OK},
    '{1'b1, 8'h50, 32'h400, RESP_OK}, '{1'b1, 8'h54, 32'h400, RESP_OK},
    '{1'b1, 8'h58, 32'h00ff0034, RESP_OK}, '{1'b1, 8'h60, 32'h180, RESP_OK},
    '{1'b1, 8'h64, 32'h3ff, RESP_OK}, '{1'b1, OFF_QUAL0, 32'h02100110, RESP_OK},
    '{1'b1, OFF_QUAL1, 32'h10000410, RESP_OK}, '{1'b1, OFF_IRQ_MASK, 32'h1, RESP_OK}};
  tts_prow_t prows[3] = '{'{POS_START, 1'b1, 3'h3}, '{POS_CENTRE, 1'b0, 3'h3}, '{POS_END, 1'b1, 3'h4}};

  tts_seq u_dut (.MCLK(MCLK), .SYS_RST(SYS_RST), .CAP_VALID(CAP_VALID), .CAP_ADDR(CAP_ADDR),
    .CAP_DATA(CAP_DATA), .CAP_STAT(CAP_STAT), .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
    .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID),
    .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA),
    .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY), .BREAK_REQ(BREAK_REQ), .IRQ(IRQ));
  tts_tgt u_tgt (.clk(MCLK), .valid(CAP_VALID), .addr(CAP_ADDR), .data(CAP_DATA), .stat(CAP_STAT));

  always #10 MCLK = ~MCLK;

  always @(posedge MCLK)
  begin
    cyc++;
    if (BREAK_REQ === 1'b1)
      brk_n++;
    if (cyc == 6000)
    begin
      num_errors++;
      close_out();
    end
  end

  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : close_out

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      $display("BAD %s expected %h seen %h", nm, e, g);
      num_errors++;
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
    logic done;
    done = 1'b0;
    @(posedge MCLK);
    AWADDR <= a;
    WDATA <= d;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    while (!done)
    begin
      @(posedge MCLK);
      if (AWVALID && AWREADY === 1'b1)
        AWVALID <= 1'b0;
      if (WVALID && WREADY === 1'b1)
        WVALID <= 1'b0;
      if (BVALID === 1'b1)
      begin
        rs = BRESP;
        BREADY <= 1'b0;
        done = 1'b1;
      end
    end
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
    logic done;
    done = 1'b0;
    @(posedge MCLK);
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    while (!done)
    begin
      @(posedge MCLK);
      if (ARVALID && ARREADY === 1'b1)
        ARVALID <= 1'b0;
      if (RVALID === 1'b1)
      begin
        d = RDATA;
        rs = RRESP;
        RREADY <= 1'b0;
        done = 1'b1;
      end
    end
  endtask : rd

  // Send one state, then confirm the level it leaves the sequencer at
  task automatic step(input logic [23:0] a, input logic [15:0] d, input logic [2:0] s);
    logic [31:0] sv;
    logic [1:0] sr;
    u_tgt.send(a, d);
    rd(OFF_STAT, sv, sr);
    chk("level", {29'h0, s}, {29'h0, sv[2:0]});
  endtask : step

  task automatic ent(input logic [5:0] i, input logic [23:0] e);
    logic [31:0] ev;
    logic [1:0] er;
    wr(OFF_BUF_IDX, {26'h0, i}, er);
    repeat (2) @(posedge MCLK);
    rd(OFF_BUF_ADDR, ev, er);
    chk("entry", {8'h0, e}, ev);
  endtask : ent

  initial
  begin
    repeat (3) @(posedge MCLK);
    chk("rst ready", 32'h7, {29'h0, AWREADY, WREADY, ARREADY});
    chk("rst outs", 32'h0, {28'h0, BVALID, RVALID, BREAK_REQ, IRQ});
    SYS_RST <= 1'b0;
    foreach (rrows[i])
    begin
      if (rrows[i].w)
        wr(rrows[i].a, rrows[i].d, r);
      else
      begin
        rd(rrows[i].a, v, r);
        chk("reg data", rrows[i].d, v);
      end
      chk("reg resp", {30'h0, rrows[i].r}, {30'h0, r});
    end
    // Only byte lane 1 may change; the low mask bits must survive
    WSTRB <= 4'h2;
    wr(OFF_IRQ_MASK, 32'hffffffff, r);
    WSTRB <= 4'hf;
    rd(OFF_IRQ_MASK, v, r);
    chk("strobe", 32'h0000ff01, v);
    $display("test registers done");
    foreach (prows[i])
    begin
      rd(OFF_IRQ_STAT, v, r);
      b0 = brk_n;
      wr(OFF_CTRL, {28'h0, prows[i].brk, prows[i].pos, 1'b1}, r);
      step(24'h000050, 16'h0, 3'h1);
      step(24'h000180, 16'h0, 3'h1);
      step(24'h000100, 16'h0, 3'h2);
      step(24'h000400, 16'h1235, 3'h2);
      step(24'h000300, 16'h0, 3'h1);
      step(24'h000100, 16'h0, 3'h2);
      step(24'h000400, 16'h1234, prows[i].seq);
      chk("break", {31'h0, prows[i].brk}, 32'(brk_n - b0));
      chk("irq on", 32'h1, {31'h0, IRQ});
      rd(OFF_IRQ_STAT, v, r);
      chk("irq bit", 32'h1, {31'h0, v[IRQ_TRIG]});
      chk("done bit", {31'h0, prows[i].pos == POS_END}, {31'h0, v[IRQ_DONE]});
      repeat (3) @(posedge MCLK);
      chk("irq off", 32'h0, {31'h0, IRQ});
      step(24'h000777, 16'h0, prows[i].seq);
      rd(OFF_STAT, st, r);
      idx = st[21:16];
      ent(idx, 24'h000400);
      rd(OFF_BUF_DS, v, r);
      chk("entry ds", 32'h00011234, v);
      if (prows[i].pos == POS_START)
      begin
        chk("trig idx", 32'h0, {26'h0, idx});
        ent(6'h01, 24'h000777);
      end
      if (prows[i].pos == POS_END)
        chk("end ptr", {26'h0, idx + 6'h1}, {26'h0, st[13:8]});
      $display("test position %0d done", i);
    end
    wr(OFF_CTRL, 32'h11, r);
    rd(OFF_COUNT, st, r);
    rd(OFF_COUNT, v, r);
    chk("time count", 32'h1, {31'h0, v > st});
    wr(OFF_CTRL, 32'h01, r);
    step(24'h000050, 16'h0, 3'h1);
    rd(OFF_COUNT, v, r);
    chk("count off", 32'h0, v);
    wr(8'h70, 32'h500, r);
    wr(8'h74, 32'h5ff, r);
    wr(OFF_QUAL1, 32'h10080001, r);
    wr(OFF_CTRL, 32'h21, r);
    step(24'h000100, 16'h0, 3'h2);
    step(24'h000400, 16'h1234, 3'h3);
    step(24'h000510, 16'h0, 3'h3);
    step(24'h000520, 16'h0, 3'h3);
    step(24'h000530, 16'h0, 3'h3);
    step(24'h000100, 16'h0, 3'h3);
    ent(6'h01, 24'h000520);
    ent(6'h02, 24'h000530);
    ent(6'h03, 24'h000100);
    rd(OFF_COUNT, v, r);
    chk("state count", 32'h6, v);
    $display("test count and prestore done");
    wr(OFF_CTRL, 32'h40, r);
    rd(OFF_STAT, v, r);
    chk("stopped", 32'h0, {29'h0, v[2:0]});
    wr(OFF_CTRL, 32'h01, r);
    SYS_RST <= 1'b1;
    repeat (2) @(posedge MCLK);
    SYS_RST <= 1'b0;
    rd(OFF_CTRL, v, r);
    chk("ctrl after reset", CTRL_RST, v);
    rd(OFF_STAT, v, r);
    chk("idle after reset", 32'h0, {29'h0, v[2:0]});
    $display("test second reset done");
    close_out();
  end
endmodule : tts_seq_tb

/* testbench/tts_tgt.sv */
// Target bus model: presents captured bus states to the sequencer.
// Assumes the sequencer takes the fields within three cycles of the valid rise.
`timescale 1ns/1ps
module tts_tgt
  import tts_pkg::*;
(
  input wire logic clk,
  output logic valid,
  output logic [AW-1:0] addr,
  output logic [DW-1:0] data,
  output logic [SW-1:0] stat
);
  initial
  begin
    valid = 1'b0;
    addr = '0;
    data = '0;
    stat = '0;
  end

  task automatic send(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge clk);
    valid <= 1'b1;
    addr <= a;
    data <= d;
    stat <= 4'h1;
    repeat (4) @(posedge clk);
    valid <= 1'b0;
    // Fields are not held after valid drops, so never leave a stale match behind
    addr <= ~a;
    data <= ~d;
    stat <= 4'he;
    repeat (6) @(posedge clk);
  endtask : send
endmodule : tts_tgt
